/* pkg/tuma_pkg.sv */
// constants and types shared by the text unit memory arbiter
package tuma_pkg;
    localparam int           EXT_AW        = 19;
    localparam int           CPU_AW        = 16;
    localparam int           DW            = 8;
    localparam int           SYS_CLK_HZ    = 100_000_000;
    localparam int           CPU_CLK_HZ    = 10_125_000;
    localparam int           CPU_DIV       = SYS_CLK_HZ / CPU_CLK_HZ;
    localparam int           VBI_LINES     = 22;
    localparam int           LINE_BYTES    = 43;
    localparam int           PAGE_BYTES    = 1024;
    localparam int           GHOST_BYTES   = 128;
    localparam int           RAM_BYTES     = 640;
    localparam logic [15:0]  ZP_LO         = 16'h0000;
    localparam logic [15:0]  ZP_HI         = 16'h00FF;
    localparam logic [15:0]  STK_LO        = 16'h0100;
    localparam logic [15:0]  STK_HI        = 16'h01FF;
    localparam logic [15:0]  OSD_LO        = 16'h0100;
    localparam logic [15:0]  OSD_HI        = 16'h019F;
    localparam logic [15:0]  IO_LO         = 16'h0200;
    localparam logic [15:0]  IO_HI         = 16'h02FF;
    localparam logic [15:0]  XP_LO         = 16'h0300;
    localparam logic [15:0]  XP_HI         = 16'h037F;
    localparam logic [15:0]  CROM_LO       = 16'h5000;
    localparam logic [15:0]  CROM_HI       = 16'h7FFF;
    localparam logic [15:0]  PROM_LO       = 16'hD000;
    localparam logic [15:0]  PROM_HI       = 16'hFFFF;
    localparam logic [15:0]  VEC_IRQ       = 16'hFFFE;
    localparam logic [15:0]  VEC_RST       = 16'hFFFC;
    localparam logic [15:0]  VEC_NMI       = 16'hFFFA;
    localparam logic [15:0]  CTRL_WORD     = 16'hFFF9;
    localparam logic [18:0]  SCRATCH_BASE  = 19'h01000;
    localparam logic [18:0]  PAGE_BASE_EXT = 19'h04000;
    localparam logic [18:0]  PAGE_BASE_INT = 19'h00000;
    localparam logic [18:0]  DISP_BASE_EXT = 19'h03000;
    localparam logic [18:0]  DISP_BASE_INT = 19'h00000;

    typedef enum logic [2:0] {
        TUMA_SEG_NONE,
        TUMA_SEG_RAM,
        TUMA_SEG_IO,
        TUMA_SEG_CROM,
        TUMA_SEG_PROM,
        TUMA_SEG_EXT
    } tuma_seg_t;

    typedef enum logic [1:0] {
        TUMA_SRC_CPU,
        TUMA_SRC_SLC,
        TUMA_SRC_DSP
    } tuma_src_t;
endpackage

/* pkg/tuma_dma_if.sv */
// request/answer bundle between arbiter and rom dma path
`timescale 1ns/1ns
interface tuma_dma_if;
    logic        req;
    logic        from_crom;
    logic [15:0] addr;
    logic        ack;
    logic [7:0]  rdata;
    modport arb (output req, output from_crom, output addr, input ack, input rdata);
    modport dma (input req, input from_crom, input addr, output ack, output rdata);
endinterface

/* core/tuma_rom_dma.sv */
// dma path into character and program rom with inserted wait cycles
`timescale 1ns/1ns
module tuma_rom_dma #(
    parameter int WAIT_CYC = 2
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // rom read ports
    output logic [15:0]      rom_addr_o,
    input  wire logic [7:0]  crom_data_i,
    input  wire logic [7:0]  prom_data_i,
    // arbiter side
    tuma_dma_if.dma          bus
);
    logic [3:0] cnt;
    logic       busy;
    logic       sel_c;
    wire        done = busy && (cnt == 4'(WAIT_CYC));

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt        <= 4'h0;
            busy       <= 1'b0;
            sel_c      <= 1'b0;
            rom_addr_o <= 16'h0000;
            bus.ack    <= 1'b0;
            bus.rdata  <= 8'h00;
        end
        else
        begin
            bus.ack <= 1'b0;
            if (!busy && bus.req && !bus.ack)
            begin
                busy       <= 1'b1;
                cnt        <= 4'h0;
                sel_c      <= bus.from_crom;
                rom_addr_o <= bus.addr;
            end
            else if (done)
            begin
                // wait cycles stretch every rom fetch
                busy      <= 1'b0;
                bus.ack   <= 1'b1;
                bus.rdata <= sel_c ? crom_data_i : prom_data_i;
            end
            else if (busy)
                cnt <= cnt + 4'h1;
        end
    end
endmodule

/* core/tuma_arbiter.sv */
// external sram arbiter and cpu memory decode of the text processing unit
//
// Summary of operation
// - A 19-bit sram address reaches parts up to 4 Mbit and smaller ones too.
// - Cpu, slicer and display controller are three independent request streams.
// - The cpu may read and write any sram location.
// - The slicer writes up to 22 lines of 43 bytes into the acquisition scratch area.
// - The display controller fetches text rows from display memory into its row buffer.
// - After reset no sram access happens until the host enable command arrives.
// - The cpu runs at 100 MHz / 9, about 11.1 MHz, with a 64 kByte address space.
// - Internal memory is 640 bytes ram, 12 kBytes program rom and 12 kBytes character rom.
// - Character rom is reached by the cpu only through a dma path with wait cycles.
// - The display controller reads character and program rom through the same dma path.
// - Vectors sit at FFFE, FFFC, FFFA low byte first, control word at FFF9.
// - Cpu addresses decode into zero page, stack, osd, io, extra page and roms.
// - Every sliced line is stored, page selection is left to software.
// - Pages take fixed 1 kByte slots, ghost rows chain in 128 byte segments.
// - Without external sram display memory fetches get no answer, display rom fetches still go through dma.
`timescale 1ns/1ns
module tuma_arbiter #(
    parameter int EXT_AW = tuma_pkg::EXT_AW,
    parameter int DMA_WAIT = 2
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    // host command decode
    input  wire logic               ext_mem_en_i,
    input  wire logic               sram_present_i,
    // cpu bus
    input  wire logic               cpu_req_i,
    input  wire logic               cpu_we_i,
    input  wire logic [15:0]        cpu_addr_i,
    input  wire logic [7:0]         cpu_wdata_i,
    input  wire logic               cpu_ext_i,
    input  wire logic [EXT_AW-1:0]  cpu_ext_addr_i,
    output logic                    cpu_ce_o,
    output logic                    cpu_wait_o,
    output logic                    cpu_ack_o,
    output logic [7:0]              cpu_rdata_o,
    // slicer write stream
    input  wire logic               slc_req_i,
    input  wire logic [4:0]         slc_line_i,
    input  wire logic [5:0]         slc_byte_i,
    input  wire logic [7:0]         slc_wdata_i,
    output logic                    slc_ack_o,
    // display controller
    input  wire logic               dsp_req_i,
    input  wire logic               dsp_rom_i,
    input  wire logic [15:0]        dsp_addr_i,
    output logic                    dsp_ack_o,
    output logic [7:0]              dsp_rdata_o,
    // internal memories
    output logic [15:0]             rom_addr_o,
    input  wire logic [7:0]         crom_data_i,
    input  wire logic [7:0]         prom_data_i,
    output logic                    iram_we_o,
    output logic                    io_sel_o,
    input  wire logic [7:0]         iram_data_i,
    input  wire logic [7:0]         io_data_i,
    // external sram
    output logic [EXT_AW-1:0]       sram_addr_o,
    output logic [7:0]              sram_dq_o,
    output logic                    sram_dq_oe_o,
    input  wire logic [7:0]         sram_dq_i,
    output logic                    sram_ce_n_o,
    output logic                    sram_we_n_o,
    output logic                    sram_oe_n_o,
    // debug
    output logic                    vec_fetch_o
);
    typedef enum logic [1:0] {TUMA_IDLE, TUMA_SRAM, TUMA_DMA, TUMA_DONE} tuma_st_t;

    function automatic tuma_pkg::tuma_seg_t tuma_decode(input logic [15:0] a);
        if (a <= tuma_pkg::XP_HI && (a < tuma_pkg::IO_LO || a > tuma_pkg::IO_HI))
            tuma_decode = tuma_pkg::TUMA_SEG_RAM;
        else if (a >= tuma_pkg::IO_LO && a <= tuma_pkg::IO_HI)
            tuma_decode = tuma_pkg::TUMA_SEG_IO;
        else if (a >= tuma_pkg::CROM_LO && a <= tuma_pkg::CROM_HI)
            tuma_decode = tuma_pkg::TUMA_SEG_CROM;
        else if (a >= tuma_pkg::PROM_LO)
            tuma_decode = tuma_pkg::TUMA_SEG_PROM;
        else
            tuma_decode = tuma_pkg::TUMA_SEG_NONE;
    endfunction

    tuma_st_t            st;
    tuma_pkg::tuma_src_t src;
    logic [3:0]          div_cnt;
    logic                en_latched;
    tuma_dma_if          dma_bus();

    // cpu clock enable every 9th system clock, 100 MHz / 9 gives about 11.1 MHz
    wire       cpu_tick = (div_cnt == 4'(tuma_pkg::CPU_DIV - 1));
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_cnt <= 4'h0;
        else
            div_cnt <= cpu_tick ? 4'h0 : div_cnt + 4'h1;
    end

    // host enable is sticky until reset
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            en_latched <= 1'b0;
        else if (ext_mem_en_i)
            en_latched <= 1'b1;
    end

    wire tuma_pkg::tuma_seg_t cpu_seg = tuma_decode(cpu_addr_i);
    wire       ext_ok     = en_latched && sram_present_i;
    wire       cpu_sram   = cpu_req_i && cpu_ext_i && ext_ok;
    // program rom shares the one rom address port, so it pays the dma wait as well
    wire       cpu_rom    = cpu_req_i && !cpu_ext_i
                            && (cpu_seg == tuma_pkg::TUMA_SEG_CROM || cpu_seg == tuma_pkg::TUMA_SEG_PROM);
    wire       cpu_local  = cpu_req_i && !cpu_ext_i && !cpu_rom;
    wire       slc_in_rng = slc_line_i < 5'(tuma_pkg::VBI_LINES) && slc_byte_i < 6'(tuma_pkg::LINE_BYTES);
    wire       slc_go     = slc_req_i && slc_in_rng && ext_ok;
    wire       dsp_go     = dsp_req_i && (dsp_rom_i || ext_ok);
    wire       prom_hit   = cpu_seg == tuma_pkg::TUMA_SEG_PROM;
    wire       is_vec     = prom_hit && cpu_addr_i >= tuma_pkg::CTRL_WORD;
    // scratch slot: line times line length, every line stored unfiltered
    wire [18:0] slc_off   = 19'(slc_line_i) * 19'(tuma_pkg::LINE_BYTES) + 19'(slc_byte_i);
    wire [18:0] slc_addr  = tuma_pkg::SCRATCH_BASE + slc_off;
    // base 0 when no sram is fitted, never reaches sram_addr_o since dsp_go then needs dsp_rom_i
    wire [18:0] disp_base = sram_present_i ? tuma_pkg::DISP_BASE_EXT : tuma_pkg::DISP_BASE_INT;
    wire [18:0] dsp_ext   = disp_base + 19'(dsp_addr_i);
    wire       unlim_rd   = !cpu_we_i;

    assign dma_bus.req       = (st == TUMA_DMA);
    assign dma_bus.from_crom = (src == tuma_pkg::TUMA_SRC_CPU) ? (cpu_seg == tuma_pkg::TUMA_SEG_CROM)
                               : (dsp_addr_i >= tuma_pkg::CROM_LO && dsp_addr_i <= tuma_pkg::CROM_HI);
    assign dma_bus.addr      = (src == tuma_pkg::TUMA_SRC_CPU) ? cpu_addr_i : dsp_addr_i;

    tuma_rom_dma #(
        .WAIT_CYC (DMA_WAIT)
    ) u_dma (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .rom_addr_o  (rom_addr_o),
        .crom_data_i (crom_data_i),
        .prom_data_i (prom_data_i),
        .bus         (dma_bus)
    );

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st           <= TUMA_IDLE;
            src          <= tuma_pkg::TUMA_SRC_CPU;
            sram_addr_o  <= '0;
            sram_dq_o    <= 8'h00;
            sram_dq_oe_o <= 1'b0;
            sram_ce_n_o  <= 1'b1;
            sram_we_n_o  <= 1'b1;
            sram_oe_n_o  <= 1'b1;
            cpu_ack_o    <= 1'b0;
            cpu_rdata_o  <= 8'h00;
            slc_ack_o    <= 1'b0;
            dsp_ack_o    <= 1'b0;
            dsp_rdata_o  <= 8'h00;
            iram_we_o    <= 1'b0;
            io_sel_o     <= 1'b0;
            cpu_ce_o     <= 1'b0;
            vec_fetch_o  <= 1'b0;
        end
        else
        begin
            cpu_ack_o   <= 1'b0;
            slc_ack_o   <= 1'b0;
            dsp_ack_o   <= 1'b0;
            iram_we_o   <= 1'b0;
            cpu_ce_o    <= cpu_tick;
            vec_fetch_o <= cpu_req_i && is_vec;
            case (st)
                TUMA_IDLE:
                begin
                    // stream requests first, cpu is stalled meanwhile
                    if (slc_go)
                    begin
                        st           <= TUMA_SRAM;
                        src          <= tuma_pkg::TUMA_SRC_SLC;
                        sram_addr_o  <= EXT_AW'(slc_addr);
                        sram_dq_o    <= slc_wdata_i;
                        sram_dq_oe_o <= 1'b1;
                        sram_ce_n_o  <= 1'b0;
                        sram_we_n_o  <= 1'b0;
                    end
                    else if (dsp_go)
                    begin
                        src <= tuma_pkg::TUMA_SRC_DSP;
                        if (dsp_rom_i)
                            st <= TUMA_DMA;
                        else
                        begin
                            st          <= TUMA_SRAM;
                            sram_addr_o <= EXT_AW'(dsp_ext);
                            sram_ce_n_o <= 1'b0;
                            sram_oe_n_o <= 1'b0;
                        end
                    end
                    else if (cpu_sram)
                    begin
                        st           <= TUMA_SRAM;
                        src          <= tuma_pkg::TUMA_SRC_CPU;
                        sram_addr_o  <= cpu_ext_addr_i;
                        sram_dq_o    <= cpu_wdata_i;
                        sram_dq_oe_o <= cpu_we_i;
                        sram_ce_n_o  <= 1'b0;
                        sram_we_n_o  <= !cpu_we_i;
                        sram_oe_n_o  <= !unlim_rd;
                    end
                    else if (cpu_rom)
                    begin
                        st  <= TUMA_DMA;
                        src <= tuma_pkg::TUMA_SRC_CPU;
                    end
                    else if (cpu_local && !cpu_ack_o)
                    begin
                        // internal ram and io answer in one cycle
                        st          <= TUMA_DONE;
                        cpu_ack_o   <= 1'b1;
                        iram_we_o   <= cpu_we_i && cpu_seg == tuma_pkg::TUMA_SEG_RAM;
                        io_sel_o    <= cpu_seg == tuma_pkg::TUMA_SEG_IO;
                        cpu_rdata_o <= cpu_seg == tuma_pkg::TUMA_SEG_IO ? io_data_i : iram_data_i;
                    end
                end
                TUMA_SRAM:
                begin
                    // one cycle strobe then release the bus
                    st           <= TUMA_DONE;
                    sram_ce_n_o  <= 1'b1;
                    sram_we_n_o  <= 1'b1;
                    sram_oe_n_o  <= 1'b1;
                    sram_dq_oe_o <= 1'b0;
                    slc_ack_o    <= src == tuma_pkg::TUMA_SRC_SLC;
                    dsp_ack_o    <= src == tuma_pkg::TUMA_SRC_DSP;
                    cpu_ack_o    <= src == tuma_pkg::TUMA_SRC_CPU;
                    if (src == tuma_pkg::TUMA_SRC_DSP)
                        dsp_rdata_o <= sram_dq_i;
                    if (src == tuma_pkg::TUMA_SRC_CPU)
                        cpu_rdata_o <= sram_dq_i;
                end
                TUMA_DMA:
                begin
                    if (dma_bus.ack)
                    begin
                        st        <= TUMA_DONE;
                        cpu_ack_o <= src == tuma_pkg::TUMA_SRC_CPU;
                        dsp_ack_o <= src == tuma_pkg::TUMA_SRC_DSP;
                        if (src == tuma_pkg::TUMA_SRC_CPU)
                            cpu_rdata_o <= dma_bus.rdata;
                        else
                            dsp_rdata_o <= dma_bus.rdata;
                    end
                end
                TUMA_DONE:
                begin
                    // requester drops its request during this cycle
                    st       <= TUMA_IDLE;
                    io_sel_o <= 1'b0;
                end
                default:
                    st <= TUMA_IDLE;
            endcase
        end
    end

    // wait asserted while a cpu request is pending and not yet answered
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cpu_wait_o <= 1'b0;
        else
            cpu_wait_o <= cpu_req_i && !(st == TUMA_IDLE && cpu_local && !slc_go && !dsp_go)
                          && !(cpu_ack_o);
    end
endmodule

/* dv/tuma_sram_model.sv */
// behavioural external sram on the shared memory bus
`timescale 1ns/1ns
module tuma_sram_model (
    // sram pins
    input  wire logic        clk_sys_i,
    input  wire logic [18:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    output logic [7:0]       dq_o
);
    // plain async sram has no wait pin, so it can only answer at once
    logic [7:0] mem [0:524287];
    logic [7:0] last = 8'h00;
    wire        rd = !ce_n_i && !oe_n_i;
    always @(posedge clk_sys_i)
    begin
        if (!ce_n_i && !we_n_i)
            mem[addr_i] <= dq_i;
        if (rd)
            last <= dq_o;
    end
    // released bus shows the inverse, never a held value
    assign dq_o = rd ? mem[addr_i] : ~last;
endmodule

/* dv/tuma_arbiter_monitor.sv */
// concurrent checks on the memory arbiter ports
`timescale 1ns/1ns
module tuma_arbiter_monitor #(
    parameter int EXT_AW = 19
) (
    // watched ports
    input wire logic              clk_sys_i,
    input wire logic              rstn_i,
    input wire logic              ext_mem_en_i,
    input wire logic              sram_present_i,
    input wire logic              cpu_req_i,
    input wire logic [15:0]       cpu_addr_i,
    input wire logic              cpu_ce_o,
    input wire logic              cpu_ack_o,
    input wire logic [4:0]        slc_line_i,
    input wire logic [5:0]        slc_byte_i,
    input wire logic              slc_ack_o,
    input wire logic              dsp_ack_o,
    input wire logic [EXT_AW-1:0] sram_addr_o,
    input wire logic              sram_dq_oe_o,
    input wire logic              sram_ce_n_o,
    input wire logic              sram_we_n_o,
    input wire logic              vec_fetch_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic              en_seen;
    wire  [EXT_AW-1:0] slc_exp = EXT_AW'(tuma_pkg::SCRATCH_BASE) + EXT_AW'(slc_line_i) * EXT_AW'(6'h2B)
                                 + EXT_AW'(slc_byte_i);
    always_ff @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            en_seen <= 1'b0;
        else
            en_seen <= en_seen | ext_mem_en_i;
    sequence s_wr_strobe;
        !sram_ce_n_o && !sram_we_n_o && sram_dq_oe_o;
    endsequence
    sequence s_ce_gap;
        !cpu_ce_o [*8] ##1 cpu_ce_o;
    endsequence
    a_no_early_access: assert property (!en_seen |-> sram_ce_n_o)
        else $error("sram access before enable");
    a_absent_no_access: assert property (!sram_present_i && $past(sram_present_i) == 1'b0 |-> sram_ce_n_o)
        else $error("sram access without sram");
    a_write_strobe: assert property ($fell(sram_we_n_o) |-> s_wr_strobe ##1 sram_we_n_o)
        else $error("bad write strobe");
    a_slicer_addr: assert property (slc_ack_o |-> $past(sram_we_n_o) == 1'b0 && $past(sram_addr_o) == slc_exp)
        else $error("slicer write address wrong");
    a_slicer_range: assert property (slc_ack_o |-> slc_line_i < 5'h16 && slc_byte_i < 6'h2B)
        else $error("slicer out of range acked");
    a_one_ack: assert property ($onehot0({cpu_ack_o, slc_ack_o, dsp_ack_o}))
        else $error("two streams acked together");
    a_cpu_clock: assert property (cpu_ce_o |=> s_ce_gap)
        else $error("cpu clock enable period wrong");
    a_vector_flag: assert property ($rose(vec_fetch_o) |-> $past(cpu_req_i) && $past(cpu_addr_i) >= 16'hFFF9)
        else $error("vector flag without vector fetch");
    a_cpu_ack_req: assert property (cpu_ack_o |-> $past(cpu_req_i))
        else $error("cpu acked without request");
endmodule
bind tuma_arbiter tuma_arbiter_monitor #(.EXT_AW(EXT_AW)) u_mon (.clk_sys_i, .rstn_i, .ext_mem_en_i,
    .sram_present_i, .cpu_req_i, .cpu_addr_i, .cpu_ce_o, .cpu_ack_o, .slc_line_i, .slc_byte_i, .slc_ack_o,
    .dsp_ack_o, .sram_addr_o, .sram_dq_oe_o, .sram_ce_n_o, .sram_we_n_o, .vec_fetch_o);

/* dv/text_unit_memory_arbiter_tb.sv */
// self-checking bench for the memory arbiter
`timescale 1ns/1ns
module text_unit_memory_arbiter_tb;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        en = 1'b0;
    logic        pres = 1'b1;
    logic        c_req = 1'b0, c_we = 1'b0, c_ext = 1'b0, s_req = 1'b0, d_req = 1'b0, d_rom = 1'b0;
    logic [15:0] c_a = 16'h0000, d_a = 16'h0000;
    logic [18:0] c_xa = 19'h00000;
    logic [7:0]  c_wd = 8'h00, s_wd = 8'h00, rd;
    logic [4:0]  s_ln = 5'h00;
    logic [5:0]  s_by = 6'h00;
    wire logic   c_ce, c_wt, c_ack, s_ack, d_ack, i_we, io_s, oe, ce_n, we_n, oe_n, vf;
    wire logic [7:0]  c_rd, d_rd, dq_o, dq_i;
    wire logic [15:0] ra;
    wire logic [18:0] sa;
    wire logic [2:0]  acks = {d_ack, s_ack, c_ack};
    wire logic [7:0]  crom = ra[7:0] ^ 8'h3C;
    wire logic [7:0]  prom = ra[7:0] ^ 8'hA5;
    int failures = 0, comparisons = 0, cycles = 0, n, m;
    always #5 clk_sys_i = ~clk_sys_i;
    tuma_arbiter DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ext_mem_en_i(en), .sram_present_i(pres),
        .cpu_req_i(c_req), .cpu_we_i(c_we), .cpu_addr_i(c_a), .cpu_wdata_i(c_wd), .cpu_ext_i(c_ext),
        .cpu_ext_addr_i(c_xa), .cpu_ce_o(c_ce), .cpu_wait_o(c_wt), .cpu_ack_o(c_ack), .cpu_rdata_o(c_rd),
        .slc_req_i(s_req), .slc_line_i(s_ln), .slc_byte_i(s_by), .slc_wdata_i(s_wd), .slc_ack_o(s_ack),
        .dsp_req_i(d_req), .dsp_rom_i(d_rom), .dsp_addr_i(d_a), .dsp_ack_o(d_ack), .dsp_rdata_o(d_rd),
        .rom_addr_o(ra), .crom_data_i(crom), .prom_data_i(prom), .iram_we_o(i_we), .io_sel_o(io_s),
        .iram_data_i(8'h11), .io_data_i(8'h22), .sram_addr_o(sa), .sram_dq_o(dq_o), .sram_dq_oe_o(oe),
        .sram_dq_i(dq_i), .sram_ce_n_o(ce_n), .sram_we_n_o(we_n), .sram_oe_n_o(oe_n), .vec_fetch_o(vf));
    tuma_sram_model SRAM (.clk_sys_i(clk_sys_i), .addr_i(sa), .dq_i(dq_o), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .dq_o(dq_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h (%0d)", $time, seen, exp, failures);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // 40 cycles with no answer counts as refused
    task automatic wait_ack(input int k, output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1 c++;
        end while (acks[k] !== 1'b1 && c < 40);
    endtask
    task automatic cpu(input logic x, w, input logic [15:0] a, input logic [18:0] xa, input logic [7:0] wd);
        @(negedge clk_sys_i);
        {c_req, c_ext, c_we, c_a, c_xa, c_wd} = {1'b1, x, w, a, xa, wd};
        wait_ack(0, n);
        rd = c_rd;
        @(negedge clk_sys_i);
        c_req = 1'b0;
    endtask
    task automatic slc(input logic [4:0] l, input logic [5:0] b, input logic [7:0] d);
        @(negedge clk_sys_i);
        {s_req, s_ln, s_by, s_wd} = {1'b1, l, b, d};
        wait_ack(1, n);
        @(negedge clk_sys_i);
        s_req = 1'b0;
    endtask
    task automatic dsp(input logic r, input logic [15:0] a);
        @(negedge clk_sys_i);
        {d_req, d_rom, d_a} = {1'b1, r, a};
        wait_ack(2, n);
        rd = d_rd;
        @(negedge clk_sys_i);
        d_req = 1'b0;
    endtask
    task automatic t_before_enable();
        check({ce_n, we_n, oe_n, c_ack, s_ack, d_ack, oe}, 7'h70);
        slc(5'h00, 6'h00, 8'h99);
        check(n, 40);
        @(negedge clk_sys_i);
        en = 1'b1;
        @(negedge clk_sys_i);
        en = 1'b0;
    endtask
    task automatic t_slicer();
        logic [18:0] a;
        for (int i = 0; i < 4; i++)
        begin
            a = 19'h01000 + (i[1] ? 19'h00387 : 19'h00000) + (i[0] ? 19'h0002A : 19'h00000);
            slc(i[1] ? 5'h15 : 5'h00, i[0] ? 6'h2A : 6'h00, 8'h5A + 8'(i));
            check(n, 2);
            check(SRAM.mem[a], 8'h5A + 8'(i));
            cpu(1'b1, 1'b0, 16'h0000, a, 8'h00);
            check(rd, 8'h5A + 8'(i));
        end
        slc(5'h16, 6'h00, 8'h01);
        check(n, 40);
        slc(5'h00, 6'h2B, 8'h01);
        check(n, 40);
    endtask
    task automatic t_cpu_ext();
        for (int i = 0; i < 2; i++)
        begin
            cpu(1'b1, 1'b1, 16'h0000, i ? 19'h7FFFF : 19'h00000, 8'hC3 ^ 8'(i));
            check(n, 2);
            cpu(1'b1, 1'b0, 16'h0000, i ? 19'h7FFFF : 19'h00000, 8'h00);
            check(rd, 8'hC3 ^ 8'(i));
        end
    endtask
    task automatic t_priority();
        @(negedge clk_sys_i);
        {c_req, c_ext, c_we, c_xa, s_req, s_ln, s_by} = {1'b1, 1'b1, 1'b0, 19'h00010, 1'b1, 5'h01, 6'h01};
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (acks === 3'h0 && n < 40);
        check({c_ack, s_ack}, 2'h1);
        check(c_wt, 1'b1);
        @(negedge clk_sys_i);
        s_req = 1'b0;
        wait_ack(0, n);
        check(c_ack, 1'b1);
        @(negedge clk_sys_i);
        c_req = 1'b0;
        @(posedge clk_sys_i);
        #1 check(c_wt, 1'b0);
    endtask
    task automatic t_display();
        SRAM.mem[19'h03123] = 8'h77;
        dsp(1'b0, 16'h0123);
        check(rd, 8'h77);
        dsp(1'b1, 16'hD044);
        check(rd, 8'hE1);
        dsp(1'b1, 16'h5044);
        check(rd, 8'h78);
    endtask
    task automatic t_decode();
        logic [15:0] ad [10] = '{16'h0010, 16'h0150, 16'h0210, 16'h0310, 16'h5123, 16'h7FFF, 16'hD010,
                                  16'hFFFC, 16'hFFFE, 16'hFFFA};
        logic [7:0] e;
        for (int i = 0; i < 10; i++)
        begin
            e = ad[i] >= 16'hD000 ? ad[i][7:0] ^ 8'hA5 : ad[i] >= 16'h5000 ? ad[i][7:0] ^ 8'h3C : 
                ad[i][15:8] == 8'h02 ? 8'h22 : 8'h11;
            cpu(1'b0, 1'b0, ad[i], 19'h00000, 8'h00);
            check(rd, e);
            check({io_s, i_we}, {ad[i][15:8] == 8'h02, 1'b0});
            if (i == 0)
                m = n;
            if (i == 4)
                check(n > m, 1'b1);
        end
        cpu(1'b0, 1'b1, 16'h0020, 19'h00000, 8'h44);
        check(i_we, 1'b1);
    endtask
    task automatic t_no_sram();
        pres = 1'b0;
        cpu(1'b1, 1'b1, 16'h0000, 19'h00040, 8'h12);
        check(n, 40);
        pres = 1'b1;
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        t_before_enable();
        t_slicer();
        t_cpu_ext();
        t_priority();
        t_display();
        t_decode();
        t_no_sram();
        finish_test();
    end
endmodule
